// ---- shared/instr_exec_map.vh ----
/*
  Constants for the add, AND, bit-clear and conditional-branch execute slice:
  opcode patterns, field positions, status bit positions and phase codes.
  Assumes it is included by bare name from each design file that needs it.
*/
`ifndef INSTR_EXEC_MAP_VH
`define INSTR_EXEC_MAP_VH

// Opcode patterns compared against the top bits of the instruction word.
`define OPC_ADDC_HI 6'h08
`define OPC_ANDF_HI 6'h05
`define OPC_ANDL_HI 8'h0B
`define OPC_BCLR_HI 4'h9
`define OPC_BRC_HI 8'hE2
`define OPC_BRNC_HI 8'hE3
`define OPC_BRN_HI 8'hE6

// Instruction field positions.
`define FLD_D_BIT 9
`define FLD_A_BIT 8
`define FLD_B_LSB 9
`define FLD_B_MSB 11

// Status bit positions inside the five-bit flag vector.
`define ST_UNSIGNED 0
`define ST_HALF 1
`define ST_LOW 2
`define ST_SIGNED 3
`define ST_TOP 4

// Address at or below which indexed literal offset addressing applies.
`define IDX_LIMIT 8'h5F
// Access-bank split: low addresses go to bank 0, the rest to the top bank.
`define ACC_SPLIT 8'h60
`define ACC_HIGH_BANK 4'hF
`define ACC_LOW_BANK 4'h0

// Reset values.
`define RST_BYTE 8'h00
`define RST_FLAGS 5'h00
`define RST_PC 21'h00_0000

// Quarter-phase one-hot codes.
`define PH_Q1 4'h1
`define PH_Q2 4'h2
`define PH_Q3 4'h4
`define PH_Q4 4'h8

`endif

// ---- hdl/quarter_phase_gen.v ----
/*
  Quarter-phase generator: a one-hot ring that splits the core clock into
  four phases forming one instruction cycle.
  Assumes a synchronised active-low reset in the core clock domain.
*/
`timescale 1ns/10ps
`include "instr_exec_map.vh"

module quarter_phase_gen (
  input wire clk_in,
  input wire rst_n_in,
  output reg [3:0] phase_out
);

  // Rotate the one-hot phase every clock; the ring restarts at the first phase.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_out <= `PH_Q1;
    end else begin
      phase_out <= {phase_out[2:0], phase_out[3]};
    end
  end

endmodule

// ---- hdl/add_and_branch_instr_exec.v ----
/*
  Execute slice of an 8-bit core: add with carry, AND with literal or file,
  bit clear of a file register and three conditional relative branches.
  Assumes the fetch unit holds instr_in stable for a whole instruction cycle
  and that data memory returns the addressed byte combinationally on
  mem_rdata_in.
*/
`timescale 1ns/10ps
`include "instr_exec_map.vh"

module add_and_branch_instr_exec #(
  parameter PC_W = 21
) (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire [15:0] instr_in,
  input wire instr_valid_in,
  input wire ext_set_en_in,
  input wire [3:0] bank_pointer_in,
  input wire [7:0] index_base_in,
  input wire [7:0] mem_rdata_in,
  output wire [11:0] mem_addr_out,
  output reg [11:0] mem_waddr_out,
  output reg [7:0] mem_wdata_out,
  output reg mem_we_out,
  output reg [7:0] acc_out,
  output reg [4:0] status_out,
  output reg [PC_W-1:0] pc_out,
  output wire [3:0] phase_out,
  output reg stall_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser and phase ring.

  reg rst_meta;
  reg rst_sync;

  // Release the reset through two flops so the whole core leaves it on one edge.
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  wire [3:0] phase;

  quarter_phase_gen u_phase (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_sync),
    .phase_out(phase)
  );

  assign phase_out = phase;

  ////////////////////////////////////////////////////////////////////////////
  // Functions used by the address and branch paths.

  // Returns the 12-bit data address for a file operand.
  function [11:0] file_addr;
    input [7:0] f;
    input a;
    input ext_en;
    input [3:0] bank;
    input [7:0] base;
    reg [7:0] idx;
    begin
      idx = base + f;
      if (a) begin
        file_addr = {bank, f};
      end else if (ext_en && (f <= `IDX_LIMIT)) begin
        file_addr = {`ACC_LOW_BANK, idx};
      end else if (f < `ACC_SPLIT) begin
        file_addr = {`ACC_LOW_BANK, f};
      end else begin
        file_addr = {`ACC_HIGH_BANK, f};
      end
    end
  endfunction

  // Sign-extends an 8-bit offset, doubles it and adds it to the counter.
  function [PC_W-1:0] branch_target;
    input [PC_W-1:0] pc;
    input [7:0] n;
    reg [PC_W-1:0] ext;
    begin
      ext = {{(PC_W-8){n[7]}}, n};
      branch_target = pc + {ext[PC_W-2:0], 1'b0};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode, held from the first quarter phase onward.

  localparam OP_NONE = 7'h00;
  localparam OP_ADDC = 7'h01;
  localparam OP_ANDL = 7'h02;
  localparam OP_ANDF = 7'h04;
  localparam OP_BCLR = 7'h08;
  localparam OP_BRC = 7'h10;
  localparam OP_BRNC = 7'h20;
  localparam OP_BRN = 7'h40;

  reg [6:0] op;
  reg [6:0] next_op;
  reg [15:0] ir;
  reg [7:0] operand;
  reg [7:0] result;
  reg [4:0] next_flags;
  reg take;
  reg kill;

  // Classify the word; other encodings fall through as no operation.
  always @* begin
    next_op = OP_NONE;
    if (instr_in[15:10] == `OPC_ADDC_HI) begin
      next_op = OP_ADDC;
    end else if (instr_in[15:8] == `OPC_ANDL_HI) begin
      next_op = OP_ANDL;
    end else if (instr_in[15:10] == `OPC_ANDF_HI) begin
      next_op = OP_ANDF;
    end else if (instr_in[15:12] == `OPC_BCLR_HI) begin
      next_op = OP_BCLR;
    end else if (instr_in[15:8] == `OPC_BRC_HI) begin
      next_op = OP_BRC;
    end else if (instr_in[15:8] == `OPC_BRNC_HI) begin
      next_op = OP_BRNC;
    end else if (instr_in[15:8] == `OPC_BRN_HI) begin
      next_op = OP_BRN;
    end
  end

  // The read address is live through the read phase from the latched word.
  assign mem_addr_out = file_addr(ir[7:0], ir[`FLD_A_BIT], ext_set_en_in,
                                  bank_pointer_in, index_base_in);

  ////////////////////////////////////////////////////////////////////////////
  // Process phase arithmetic.

  reg [4:0] low_sum;
  reg [8:0] full_sum;
  reg [7:0] clr_mask;

  // Compute the result and flags of the latched instruction.
  always @* begin
    low_sum = {1'b0, acc_out[3:0]} + {1'b0, operand[3:0]}
              + {4'h0, status_out[`ST_UNSIGNED]};
    full_sum = {1'b0, acc_out} + {1'b0, operand}
               + {8'h00, status_out[`ST_UNSIGNED]};
    clr_mask = ~(8'h01 << ir[`FLD_B_MSB:`FLD_B_LSB]);
    result = `RST_BYTE;
    next_flags = status_out;
    take = 1'b0;
    case (op)
      OP_ADDC: begin
        result = full_sum[7:0];
        next_flags[`ST_UNSIGNED] = full_sum[8];
        next_flags[`ST_HALF] = low_sum[4];
        next_flags[`ST_SIGNED] = (acc_out[7] == operand[7]) &&
                                 (full_sum[7] != acc_out[7]);
        next_flags[`ST_TOP] = full_sum[7];
        next_flags[`ST_LOW] = (full_sum[7:0] == `RST_BYTE);
      end
      OP_ANDL, OP_ANDF: begin
        result = acc_out & operand;
        next_flags[`ST_TOP] = result[7];
        next_flags[`ST_LOW] = (result == `RST_BYTE);
      end
      OP_BCLR: begin
        result = operand & clr_mask;
      end
      OP_BRC: begin
        take = status_out[`ST_UNSIGNED];
      end
      OP_BRNC: begin
        take = ~status_out[`ST_UNSIGNED];
      end
      OP_BRN: begin
        take = status_out[`ST_TOP];
      end
      default: begin
        result = `RST_BYTE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-phase sequencing.

  reg [7:0] stage_res;
  reg [4:0] stage_flags;
  reg stage_take;

  // Q1 decodes, Q2 reads, Q3 processes, Q4 commits; a killed cycle does nothing.
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      op <= OP_NONE;
      ir <= 16'h0000;
      operand <= `RST_BYTE;
      stage_res <= `RST_BYTE;
      stage_flags <= `RST_FLAGS;
      stage_take <= 1'b0;
      kill <= 1'b0;
      acc_out <= `RST_BYTE;
      status_out <= `RST_FLAGS;
      pc_out <= `RST_PC;
      mem_we_out <= 1'b0;
      mem_waddr_out <= 12'h000;
      mem_wdata_out <= `RST_BYTE;
      stall_out <= 1'b0;
    end else begin
      mem_we_out <= 1'b0;
      case (phase)
        `PH_Q1: begin
          // A taken branch turns the following cycle into a full no-op.
          if (kill || !instr_valid_in) begin
            op <= OP_NONE;
          end else begin
            op <= next_op;
          end
          ir <= instr_in;
          if (!kill) begin
            pc_out <= pc_out + {{(PC_W-2){1'b0}}, 2'b10};
          end
          stall_out <= kill;
        end
        `PH_Q2: begin
          if (op == OP_ANDL || op == OP_BRC || op == OP_BRNC || op == OP_BRN) begin
            operand <= ir[7:0];
          end else begin
            operand <= mem_rdata_in;
          end
        end
        `PH_Q3: begin
          stage_res <= result;
          stage_flags <= next_flags;
          stage_take <= take;
        end
        `PH_Q4: begin
          kill <= stage_take;
          if (stage_take) begin
            pc_out <= branch_target(pc_out, operand);
          end
          if (op == OP_ADDC || op == OP_ANDL || op == OP_ANDF) begin
            status_out <= stage_flags;
          end
          if (op == OP_ANDL ||
              ((op == OP_ADDC || op == OP_ANDF) && !ir[`FLD_D_BIT])) begin
            acc_out <= stage_res;
          end else if (op == OP_BCLR ||
                       ((op == OP_ADDC || op == OP_ANDF) && ir[`FLD_D_BIT])) begin
            mem_we_out <= 1'b1;
            mem_waddr_out <= mem_addr_out;
            mem_wdata_out <= stage_res;
          end
        end
        default: begin
          kill <= kill;
        end
      endcase
    end
  end

endmodule

// ---- dv/exec_asserts.sv ----
/* Checker for the execute slice: phase ring, write pulse, branches, AND.
   Assumes it is bound to the slice top and sees only its ports. */
`timescale 1ns/10ps
module exec_asserts #(parameter PC_W = 21) (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire [15:0] instr_in,
  input wire instr_valid_in,
  input wire mem_we_out,
  input wire [7:0] acc_out,
  input wire [4:0] status_out,
  input wire [PC_W-1:0] pc_out,
  input wire [3:0] phase_out,
  input wire stall_out
);
  // The internal reset lags two edges, so checks wait three edges.
  logic [1:0] live;
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) live <= 2'h0;
    else if (live != 2'h3) live <= live + 2'h1;
  end
  // High through the decode slot that a taken branch turns into a no-op.
  logic dropped;
  // Decode of the word taken at a live decode edge.
  wire go = phase_out == 4'h1 && instr_valid_in && !dropped;
  wire bop = instr_in[15:8] == 8'hE2 || instr_in[15:8] == 8'hE3 || instr_in[15:8] == 8'hE6;
  wire br = instr_in[15:8] == 8'hE2 && status_out[0] ||
    instr_in[15:8] == 8'hE3 && !status_out[0] || instr_in[15:8] == 8'hE6 && status_out[4];
  // The stall output lags the dropped slot by one edge, so track it here.
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) dropped <= 1'b0;
    else if (phase_out == 4'h1) dropped <= go && br;
  end
  wire [PC_W-1:0] pc_nx = pc_out + 2;
  wire [PC_W-1:0] pc_tg = pc_nx + {{(PC_W-9){instr_in[7]}}, instr_in[7:0], 1'b0};
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in || live != 2'h3);
  chk_phase_ring: assert property (
    phase_out == 4'h2 |=> phase_out == 4'h4 ##1 phase_out == 4'h8 ##1 phase_out == 4'h1)
    else $error("phase ring out of order");
  chk_we_single: assert property (mem_we_out |=> !mem_we_out)
    else $error("write pulse too long");
  chk_pc_step: assert property (go |=> pc_out == $past(pc_nx))
    else $error("counter did not step by two");
  chk_br_target: assert property (go && br |-> ##4 pc_out == $past(pc_tg, 4))
    else $error("wrong branch target");
  chk_br_idle: assert property (go && br |-> ##5 stall_out ##1
    (stall_out && !mem_we_out && $stable(pc_out))[*3])
    else $error("taken branch second cycle not idle");
  chk_no_jump: assert property (go && bop && !br |-> ##5 !stall_out)
    else $error("untaken branch stalled");
  chk_flags_kept: assert property (
    go && (bop || instr_in[15:12] == 4'h9) |=> $stable(status_out)[*4])
    else $error("flags changed");
  chk_andl_result: assert property (go && instr_in[15:8] == 8'h0B |-> ##4
    acc_out == ($past(acc_out, 4) & $past(instr_in[7:0], 4)) && status_out[4] == acc_out[7]
    && status_out[2] == (acc_out == 8'h00) && status_out[3] == $past(status_out[3], 4)
    && status_out[1:0] == $past(status_out[1:0], 4))
    else $error("literal AND result or flags wrong");
  cover property (go && br);
  cover property (mem_we_out);
  cover property (go && instr_in[15:8] == 8'h0B);
endmodule

// ---- dv/file_mem_model.sv ----
/* Banked data memory model facing the execute slice.
   Assumes reads are combinational and writes land on the clock edge. */
`timescale 1ns/10ps
module file_mem_model (
  input wire clk_in,
  input wire [11:0] raddr_in,
  output wire [7:0] rdata_out,
  input wire [11:0] waddr_in,
  input wire [7:0] wdata_in,
  input wire we_in
);
  logic [7:0] cells [0:4095];
  // A known fill lets the bench predict every operand.
  initial foreach (cells[i]) cells[i] = 8'h5A ^ i[7:0];
  assign rdata_out = cells[raddr_in];
  // One write per pulse.
  always @(posedge clk_in) begin
    if (we_in) cells[waddr_in] <= wdata_in;
  end
endmodule

// ---- dv/tb.sv ----
/* Self-checking bench: corner and random words against a reference model.
   Assumes the memory model answers reads combinationally. */
`timescale 1ns/10ps
module tb;
  localparam PC_W = 21;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic valid = 1'b0;
  logic ext = 1'b0;
  logic [3:0] bank = 4'h0;
  logic [7:0] base = 8'h00;
  wire [7:0] rdata, wdata, acc;
  wire [11:0] addr, waddr;
  wire we, stall;
  wire [4:0] st;
  wire [PC_W-1:0] pc;
  wire [3:0] ph;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h0000_20ae;
  logic [7:0] sh [0:4095];
  logic [7:0] e_acc = 8'h00, e_wd = 8'h00;
  logic [4:0] e_st = 5'h00;
  logic [PC_W-1:0] e_pc = 21'h00_0002; // The idle decode slot after reset steps the counter.
  logic [11:0] e_wa = 12'h000;
  logic e_we = 1'b0, skip = 1'b0, e_stall = 1'b0;
  logic [15:0] corner [0:6] = '{16'h0BFF, 16'h205F, 16'h2260, 16'h9F80, 16'hE280,
    16'hE37F, 16'hE600};
  always #4 clk = ~clk;
  add_and_branch_instr_exec #(.PC_W(PC_W)) dut (.ref_clk_in(clk), .resetn_in(rst_n),
    .instr_in(instr), .instr_valid_in(valid), .ext_set_en_in(ext), .bank_pointer_in(bank),
    .index_base_in(base), .mem_rdata_in(rdata), .mem_addr_out(addr), .mem_waddr_out(waddr),
    .mem_wdata_out(wdata), .mem_we_out(we), .acc_out(acc), .status_out(st), .pc_out(pc),
    .phase_out(ph), .stall_out(stall));
  file_mem_model mem (.clk_in(clk), .raddr_in(addr), .rdata_out(rdata), .waddr_in(waddr),
    .wdata_in(wdata), .we_in(we));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Kind in bits 14:12; the last kind is any word, mostly unknown opcodes.
  function automatic logic [15:0] pick(input logic [31:0] r);
    case (r[14:12])
      3'h0: return {6'h08, r[9:0]};
      3'h1: return {6'h05, r[9:0]};
      3'h2: return {8'h0B, r[7:0]};
      3'h3: return {4'h9, r[11:0]};
      3'h4: return {8'hE2, r[7:0]};
      3'h5: return {8'hE3, r[7:0]};
      3'h6: return {8'hE6, r[7:0]};
      default: return r[31:16];
    endcase
  endfunction
  function automatic logic [11:0] fa(input logic [7:0] f, input logic a);
    if (a) return {bank, f};
    if (ext && f <= 8'h5F) return {4'h0, base + f};
    return (f < 8'h60) ? {4'h0, f} : {4'hF, f};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reference step; the word after a taken branch is dropped.
  task automatic predict(input logic [15:0] w);
    logic [11:0] ad;
    logic [7:0] v, r;
    logic [8:0] s;
    ad = fa(w[7:0], w[8]);
    v = sh[ad];
    e_we = 1'b0;
    e_stall = skip;
    if (skip) begin
      skip = 1'b0;
      return;
    end
    e_pc = e_pc + 21'h00_0002;
    r = e_acc & (w[15:8] == 8'h0B ? w[7:0] : v);
    s = e_acc + v + e_st[0];
    if (w[15:10] == 6'h08) begin
      e_st = {s[7], e_acc[7] == v[7] && s[7] != e_acc[7], s[7:0] == 8'h00,
        e_acc[3:0] + v[3:0] + e_st[0] > 5'h0F, s[8]};
      r = s[7:0];
    end
    if (w[15:8] == 8'h0B || w[15:10] == 6'h05) e_st = {r[7], e_st[3], r == 8'h00, e_st[1:0]};
    if (w[15:8] == 8'h0B) e_acc = r;
    if (w[15:12] == 4'h9) r = v & ~(8'h01 << w[11:9]);
    if (w[15:10] == 6'h08 || w[15:10] == 6'h05) begin
      if (!w[9]) e_acc = r;
    end
    if ((w[15:10] == 6'h08 || w[15:10] == 6'h05) && w[9] || w[15:12] == 4'h9) begin
      e_we = 1'b1;
      e_wa = ad;
      e_wd = r;
      sh[ad] = r;
    end
    if (w[15:8] == 8'hE2 && e_st[0] || w[15:8] == 8'hE3 && !e_st[0] || w[15:8] == 8'hE6 && e_st[4])
    begin
      e_pc = e_pc + {{12{w[7]}}, w[7:0], 1'b0};
      skip = 1'b1;
    end
  endtask
  // Present a word at the last-phase edge, then check the previous word.
  task automatic issue(input logic [15:0] w, input logic e, input logic [7:0] b);
    do @(negedge clk); while (ph !== 4'h8);
    @(posedge clk);
    instr <= w;
    valid <= seed[3] | seed[5];
    ext <= e;
    base <= b;
    bank <= seed[11:8];
    @(negedge clk);
    chk(acc, e_acc);
    chk(st, e_st);
    chk(pc, e_pc);
    chk(stall, e_stall);
    chk(we, e_we);
    if (e_we) chk({waddr, wdata}, {e_wa, e_wd});
    predict(valid ? w : 16'hFFFF); // An invalid word is modelled as an unknown opcode.
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    foreach (sh[i]) sh[i] = 8'h5A ^ i[7:0];
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (corner[i]) issue(corner[i], 1'b1, 8'h20);
    repeat (600) begin
      seed = lfsr(seed);
      issue(pick(seed), seed[31], {1'b0, seed[30:24]});
    end
    issue(16'h0000, 1'b0, 8'h00);
    tally_and_finish();
  end
  // A hang ends the run as a failure.
  initial begin
    #(8 * 30000);
    fails++;
    tally_and_finish();
  end
endmodule
bind add_and_branch_instr_exec exec_asserts #(.PC_W(PC_W)) u_chk (.ref_clk_in(ref_clk_in),
  .resetn_in(resetn_in), .instr_in(instr_in), .instr_valid_in(instr_valid_in),
  .mem_we_out(mem_we_out), .acc_out(acc_out), .status_out(status_out), .pc_out(pc_out),
  .phase_out(phase_out), .stall_out(stall_out));
